// ===== logic/hs_pkg.sv
// Notes on behaviour
// - Dog: slow at dog front, home at Z.
// - Nonzero shift moves home past Z pulse.
// - Type code C selects dog method.
// - Data-setting takes current position as home.
// - Data-setting in home mode forces torque zero.
// - Direction 0 increments, 1 decrements.
// - Polarity 0 detects dog off, 1 on.
// - Homing speed until dog detected.
// - Creep speed after dog until home.
// - Ramp times come from the ACC and DEC registers.
// - Forward limit on forward rotation while homing.
// - Reverse limit on reverse rotation while homing.
// - Stopped in dog method: stop limit applies.
// - Done output set once home established.
// - Data-setting stops torque on mode entry.
// - Data-setting ignores dog input entirely.
package hs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_HOME_SPD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CREEP_SPD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SHIFT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FWD_TL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REV_TL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STOP_TL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_DEC = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_INT_EN = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_INT_CLR = 8'h30;
  // Control word layout
  localparam int unsigned CTRL_TYPE_LSB = 0;
  localparam int unsigned CTRL_TYPE_W = 4;
  localparam int unsigned CTRL_DIR_BIT = 4;
  localparam int unsigned CTRL_POL_BIT = 5;
  localparam logic [3:0] TYPE_DOG = 4'hc;
  localparam logic [3:0] TYPE_DATA = 4'hd;
  localparam logic [31:0] CTRL_RST = 32'h0000_002c;
  // Interrupt events
  localparam int unsigned EVT_N = 3;
  localparam int unsigned EVT_DONE = 0;
  localparam int unsigned EVT_DOG = 1;
  localparam int unsigned EVT_REFUSED = 2;
  // Pins passed through the synchroniser
  localparam int unsigned PIN_N = 6;
  localparam int unsigned PIN_MODE1 = 0;
  localparam int unsigned PIN_MODE2 = 1;
  localparam int unsigned PIN_START = 2;
  localparam int unsigned PIN_DOG = 3;
  localparam int unsigned PIN_ZPH = 4;
  localparam int unsigned PIN_ENC = 5;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_FAST = 3'b001,
    HS_CREEP = 3'b010,
    HS_WAIT_Z = 3'b011,
    HS_SHIFT = 3'b100,
    HS_DONE = 3'b101
  } hs_state_e;
endpackage : hs_pkg

// ===== logic/hs_irq_if.sv
`timescale 1ns/10ps
interface hs_irq_if #(parameter int unsigned N = 3);
  logic [N-1:0] evt;
  logic [N-1:0] en;
  logic [N-1:0] clr;
  logic [N-1:0] stat;
  logic irq;
  modport core (output evt, output en, output clr, input stat, input irq);
  modport ctl (input evt, input en, input clr, output stat, output irq);
endinterface : hs_irq_if

// ===== logic/hs_sync.sv
`timescale 1ns/10ps
module hs_sync #(
  parameter int unsigned N = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] d_i,
  output logic [N-1:0] q_o
);
  logic [N-1:0] meta_r;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_r[g] <= 1'b0;
          q_o[g] <= 1'b0;
        end else begin
          meta_r[g] <= d_i[g];
          q_o[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule : hs_sync

// ===== logic/hs_irq.sv
`timescale 1ns/10ps
module hs_irq (
  input wire logic clk_i,
  input wire logic rst_n_i,
  hs_irq_if.ctl bus
);
  logic [$bits(bus.stat)-1:0] stat_nxt;
  // A new event wins over a clear in the same cycle
  assign stat_nxt = (bus.stat & ~bus.clr) | bus.evt;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.stat <= '0;
      bus.irq <= 1'b0;
    end else begin
      bus.stat <= stat_nxt;
      bus.irq <= |(stat_nxt & bus.en);
    end
  end
endmodule : hs_irq

// ===== logic/hs_homing_sequencer.sv
`timescale 1ns/10ps
module hs_homing_sequencer #(
  parameter int unsigned SPD_W = 16,
  parameter int unsigned TL_W = 16,
  parameter int unsigned SHIFT_W = 24,
  parameter int unsigned TC_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_mode_sel_1_i,
  input wire logic op_mode_sel_2_i,
  input wire logic motion_start_bit_i,
  input wire logic dog_i,
  input wire logic zphase_i,
  input wire logic enc_step_i,
  input wire logic motor_stopped_i,
  output logic [SPD_W-1:0] speed_cmd_o,
  output logic dir_decr_o,
  output logic [TC_W-1:0] accel_tc_o,
  output logic [TC_W-1:0] decel_tc_o,
  output logic [TL_W-1:0] fwd_torque_limit_o,
  output logic [TL_W-1:0] rev_torque_limit_o,
  output logic torque_off_o,
  output logic homing_done_bit_o,
  output logic homing_done_flag_o,
  output logic irq_o
);
  import hs_pkg::*;

  // Pins arrive from the network side and from the encoder, all asynchronous
  logic [PIN_N-1:0] pins_raw;
  logic [PIN_N-1:0] pins_s;
  logic [PIN_N-1:0] pins_d_r;
  assign pins_raw = {enc_step_i, zphase_i, dog_i, motion_start_bit_i,
                     op_mode_sel_2_i, op_mode_sel_1_i};

  hs_sync #(.N(PIN_N)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  hs_irq_if #(.N(EVT_N)) irq_bus ();

  hs_irq u_irq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .bus(irq_bus)
  );

  // Settings
  logic [31:0] ctrl_r;
  logic [SPD_W-1:0] home_spd_r;
  logic [SPD_W-1:0] creep_spd_r;
  logic [SHIFT_W-1:0] shift_r;
  logic [TL_W-1:0] fwd_tl_r;
  logic [TL_W-1:0] rev_tl_r;
  logic [TL_W-1:0] stop_tl_r;
  logic [TC_W-1:0] acc_r;
  logic [TC_W-1:0] dec_r;
  logic [EVT_N-1:0] int_en_r;

  // Sequencer state
  hs_state_e state_r;
  hs_state_e state_nxt;
  logic [SHIFT_W-1:0] shift_cnt_r;
  logic [SHIFT_W-1:0] shift_cnt_nxt;
  logic done_r;
  logic done_nxt;

  // Field decode
  wire [CTRL_TYPE_W-1:0] type_code = ctrl_r[CTRL_TYPE_LSB +: CTRL_TYPE_W];
  wire dir_set = ctrl_r[CTRL_DIR_BIT];
  wire pol_set = ctrl_r[CTRL_POL_BIT];
  wire type_dog = (type_code == TYPE_DOG);
  wire type_data = (type_code == TYPE_DATA);

  wire home_mode = ~pins_s[PIN_MODE1] & ~pins_s[PIN_MODE2];
  wire start_rise = pins_s[PIN_START] & ~pins_d_r[PIN_START];
  // Polarity 1 means the dog counts as seen while the input is on
  wire dog_seen = pol_set ? pins_s[PIN_DOG] : ~pins_s[PIN_DOG];
  wire dog_seen_d = pol_set ? pins_d_r[PIN_DOG] : ~pins_d_r[PIN_DOG];
  wire dog_front = dog_seen & ~dog_seen_d;
  wire dog_rear = ~dog_seen & dog_seen_d;
  wire z_rise = pins_s[PIN_ZPH] & ~pins_d_r[PIN_ZPH];
  wire enc_rise = pins_s[PIN_ENC] & ~pins_d_r[PIN_ENC];

  wire start_ok = start_rise & home_mode;
  wire start_refused = start_rise & ~home_mode;
  wire running = (state_r == HS_FAST) || (state_r == HS_CREEP) ||
                 (state_r == HS_WAIT_Z) || (state_r == HS_SHIFT);

  // Next state
  always_comb begin
    state_nxt = state_r;
    shift_cnt_nxt = shift_cnt_r;
    done_nxt = done_r;
    case (state_r)
      HS_IDLE, HS_DONE: begin
        if (start_ok && type_dog) begin
          state_nxt = HS_FAST;
          done_nxt = 1'b0;
        end else if (start_ok && type_data) begin
          // Any position is accepted, the dog is never looked at
          state_nxt = HS_DONE;
          done_nxt = 1'b1;
        end
      end
      HS_FAST: begin
        if (dog_front) begin
          state_nxt = HS_CREEP;
        end
      end
      HS_CREEP: begin
        if (dog_rear) begin
          state_nxt = HS_WAIT_Z;
        end
      end
      HS_WAIT_Z: begin
        if (z_rise) begin
          shift_cnt_nxt = '0;
          if (shift_r == '0) begin
            state_nxt = HS_DONE;
            done_nxt = 1'b1;
          end else begin
            state_nxt = HS_SHIFT;
          end
        end
      end
      HS_SHIFT: begin
        if (enc_rise) begin
          shift_cnt_nxt = shift_cnt_r + 1'b1;
          if (shift_cnt_r + 1'b1 == shift_r) begin
            state_nxt = HS_DONE;
            done_nxt = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = HS_IDLE;
      end
    endcase
    // Leaving home mode aborts a run in progress
    if (!home_mode && running) begin
      state_nxt = HS_IDLE;
    end
  end

  // Motion and torque commands
  logic [SPD_W-1:0] speed_nxt;
  logic [TL_W-1:0] fwd_tl_nxt;
  logic [TL_W-1:0] rev_tl_nxt;
  logic torque_off_nxt;
  wire data_hold = home_mode & type_data;
  wire dog_stop = home_mode & type_dog & motor_stopped_i;

  always_comb begin
    speed_nxt = '0;
    if (state_r == HS_FAST) begin
      speed_nxt = home_spd_r;
    end else if (state_r == HS_CREEP || state_r == HS_WAIT_Z || state_r == HS_SHIFT) begin
      speed_nxt = creep_spd_r;
    end
    fwd_tl_nxt = fwd_tl_r;
    rev_tl_nxt = rev_tl_r;
    torque_off_nxt = 1'b0;
    if (data_hold) begin
      // Axis must be free to move by hand while the position is set
      fwd_tl_nxt = '0;
      rev_tl_nxt = '0;
      torque_off_nxt = 1'b1;
    end else if (dog_stop) begin
      fwd_tl_nxt = stop_tl_r;
      rev_tl_nxt = stop_tl_r;
    end
  end

  // APB slave, one wait state so that every answer comes from a flop
  wire apb_access = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire wr_en = apb_done & pwrite;
  wire sel_ctrl = (paddr == OFS_CTRL);
  wire sel_home = (paddr == OFS_HOME_SPD);
  wire sel_creep = (paddr == OFS_CREEP_SPD);
  wire sel_shift = (paddr == OFS_SHIFT);
  wire sel_fwd = (paddr == OFS_FWD_TL);
  wire sel_rev = (paddr == OFS_REV_TL);
  wire sel_stop = (paddr == OFS_STOP_TL);
  wire sel_acc = (paddr == OFS_ACC);
  wire sel_dec = (paddr == OFS_DEC);
  wire sel_stat = (paddr == OFS_STATUS);
  wire sel_istat = (paddr == OFS_INT_STAT);
  wire sel_ien = (paddr == OFS_INT_EN);
  wire sel_iclr = (paddr == OFS_INT_CLR);
  wire mapped = sel_ctrl | sel_home | sel_creep | sel_shift | sel_fwd | sel_rev |
                sel_stop | sel_acc | sel_dec | sel_stat | sel_istat | sel_ien | sel_iclr;
  // Status and clear are read-only and write-only respectively
  wire bad_dir = (pwrite & (sel_stat | sel_istat)) | (~pwrite & sel_iclr);
  wire err_nxt = ~mapped | bad_dir;

  wire [31:0] status_word = {24'h00_0000, 1'b0, torque_off_o, home_mode, done_r,
                             1'b0, state_r};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      sel_ctrl: rd_mux = ctrl_r;
      sel_home: rd_mux = 32'(home_spd_r);
      sel_creep: rd_mux = 32'(creep_spd_r);
      sel_shift: rd_mux = 32'(shift_r);
      sel_fwd: rd_mux = 32'(fwd_tl_r);
      sel_rev: rd_mux = 32'(rev_tl_r);
      sel_stop: rd_mux = 32'(stop_tl_r);
      sel_acc: rd_mux = 32'(acc_r);
      sel_dec: rd_mux = 32'(dec_r);
      sel_stat: rd_mux = status_word;
      sel_istat: rd_mux = 32'(irq_bus.stat);
      sel_ien: rd_mux = 32'(int_en_r);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign irq_bus.evt[EVT_DONE] = done_nxt & ~done_r;
  assign irq_bus.evt[EVT_DOG] = (state_r == HS_FAST) & dog_front;
  assign irq_bus.evt[EVT_REFUSED] = start_refused;
  assign irq_bus.en = int_en_r;
  assign irq_bus.clr = (wr_en & sel_iclr) ? pwdata[EVT_N-1:0] : '0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & err_nxt;
      prdata <= (apb_access & ~pwrite & ~err_nxt) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
      home_spd_r <= '0;
      creep_spd_r <= '0;
      shift_r <= '0;
      fwd_tl_r <= '0;
      rev_tl_r <= '0;
      stop_tl_r <= '0;
      acc_r <= '0;
      dec_r <= '0;
      int_en_r <= '0;
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_r <= pwdata;
      if (sel_home) home_spd_r <= pwdata[SPD_W-1:0];
      if (sel_creep) creep_spd_r <= pwdata[SPD_W-1:0];
      if (sel_shift) shift_r <= pwdata[SHIFT_W-1:0];
      if (sel_fwd) fwd_tl_r <= pwdata[TL_W-1:0];
      if (sel_rev) rev_tl_r <= pwdata[TL_W-1:0];
      if (sel_stop) stop_tl_r <= pwdata[TL_W-1:0];
      if (sel_acc) acc_r <= pwdata[TC_W-1:0];
      if (sel_dec) dec_r <= pwdata[TC_W-1:0];
      if (sel_ien) int_en_r <= pwdata[EVT_N-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_d_r <= '0;
      state_r <= HS_IDLE;
      shift_cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      pins_d_r <= pins_s;
      state_r <= state_nxt;
      shift_cnt_r <= shift_cnt_nxt;
      done_r <= done_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_cmd_o <= '0;
      dir_decr_o <= 1'b0;
      accel_tc_o <= '0;
      decel_tc_o <= '0;
      fwd_torque_limit_o <= '0;
      rev_torque_limit_o <= '0;
      torque_off_o <= 1'b0;
      homing_done_bit_o <= 1'b0;
      homing_done_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      speed_cmd_o <= speed_nxt;
      dir_decr_o <= dir_set;
      accel_tc_o <= acc_r;
      decel_tc_o <= dec_r;
      fwd_torque_limit_o <= fwd_tl_nxt;
      rev_torque_limit_o <= rev_tl_nxt;
      torque_off_o <= torque_off_nxt;
      homing_done_bit_o <= done_nxt;
      homing_done_flag_o <= done_nxt;
      irq_o <= irq_bus.irq;
    end
  end
endmodule : hs_homing_sequencer

// ===== sim/hs_seq_props.sv
`timescale 1ns/10ps
module hs_seq_props #(
  parameter int unsigned SPD_W = 16,
  parameter int unsigned TL_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic op_mode_sel_1_i,
  input wire logic op_mode_sel_2_i,
  input wire logic [SPD_W-1:0] speed_cmd_o,
  input wire logic [TL_W-1:0] fwd_torque_limit_o,
  input wire logic [TL_W-1:0] rev_torque_limit_o,
  input wire logic torque_off_o,
  input wire logic homing_done_bit_o,
  input wire logic homing_done_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence apb_access_s;
    psel && !penable ##1 psel && penable;
  endsequence
  // Six samples cover two sync flops, the state flop and the output lag
  sequence mode_left_s;
    (op_mode_sel_1_i || op_mode_sel_2_i) [*6];
  endsequence
  apb_wait_a: assert property (apb_access_s |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  done_pair_a: assert property (homing_done_bit_o == homing_done_flag_o)
    else $error("done outputs differ");
  done_stop_a: assert property ($rose(homing_done_bit_o) |=> speed_cmd_o == '0)
    else $error("speed still commanded at done");
  torque_zero_a: assert property (torque_off_o |-> !fwd_torque_limit_o && !rev_torque_limit_o)
    else $error("torque limits not zero with torque off");
  mode_abort_a: assert property (mode_left_s |-> speed_cmd_o == '0)
    else $error("motion outside home mode");
  mode_torque_a: assert property (mode_left_s |-> !torque_off_o)
    else $error("torque off outside home mode");
endmodule : hs_seq_props
bind hs_homing_sequencer hs_seq_props #(.SPD_W(SPD_W), .TL_W(TL_W)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .op_mode_sel_1_i(op_mode_sel_1_i),
  .op_mode_sel_2_i(op_mode_sel_2_i), .speed_cmd_o(speed_cmd_o),
  .fwd_torque_limit_o(fwd_torque_limit_o), .rev_torque_limit_o(rev_torque_limit_o),
  .torque_off_o(torque_off_o), .homing_done_bit_o(homing_done_bit_o),
  .homing_done_flag_o(homing_done_flag_o));

// ===== sim/hs_master_model.sv
`timescale 1ns/10ps
module hs_master_model (
  input wire logic clk_i,
  output logic op_mode_sel_1_o,
  output logic op_mode_sel_2_o,
  output logic motion_start_bit_o
);
  initial begin
    op_mode_sel_1_o = 1'b1;
    op_mode_sel_2_o = 1'b0;
    motion_start_bit_o = 1'b0;
  end
  // Levels are held long past the pin synchroniser so no change is missed
  task automatic set_mode(input logic m1, input logic m2);
    op_mode_sel_1_o <= m1;
    op_mode_sel_2_o <= m2;
    repeat (6) @(posedge clk_i);
  endtask : set_mode
  task automatic start_pulse();
    motion_start_bit_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    motion_start_bit_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : start_pulse
endmodule : hs_master_model

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
  import hs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic dog_i = 1'b0;
  logic zph_i = 1'b0;
  logic enc_i = 1'b0;
  logic stop_i = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, m1, m2, st, dir, toff, dbit, dflag, irq;
  wire logic [15:0] spd, acc, dec, fwd, rev;
  logic [31:0] mdl [13];
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int compares = 0;
  always #10 clk_i = ~clk_i;
  hs_master_model far (.clk_i(clk_i), .op_mode_sel_1_o(m1), .op_mode_sel_2_o(m2),
    .motion_start_bit_o(st));
  hs_homing_sequencer DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_mode_sel_1_i(m1), .op_mode_sel_2_i(m2), .motion_start_bit_i(st),
    .dog_i(dog_i), .zphase_i(zph_i), .enc_step_i(enc_i), .motor_stopped_i(stop_i),
    .speed_cmd_o(spd), .dir_decr_o(dir), .accel_tc_o(acc), .decel_tc_o(dec),
    .fwd_torque_limit_o(fwd), .rev_torque_limit_o(rev), .torque_off_o(toff),
    .homing_done_bit_o(dbit), .homing_done_flag_o(dflag), .irq_o(irq));
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // Wide enough for the packed groups of outputs compared in one go
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    chk(n < 20, 1, "apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  function automatic logic [31:0] msk(input int i);
    case (i)
      0: return 32'h3f;
      3: return 32'hff_ffff;
      11: return 32'h7;
      default: return 32'hffff;
    endcase
  endfunction : msk
  task automatic wm(input int i, input logic [31:0] d);
    apb(1'b1, 8'(4 * i), d);
    mdl[i] = d & msk(i);
  endtask : wm
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "rdata");
    chk(err, e, "pslverr");
  endtask : rchk
  task automatic pins(input logic d, input logic z);
    dog_i <= d;
    zph_i <= z;
    tick(6);
  endtask : pins
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    void'($urandom(32'h292e280a));
    foreach (mdl[i]) mdl[i] = 32'h0;
    mdl[0] = CTRL_RST;
    tick(8);
    rst_n_i <= 1'b1;
    tick(1);
    for (int i = 0; i < 12; i++) if (i != 9 && i != 10) rchk(8'(4 * i), mdl[i], 1'b0);
    for (int i = 1; i < 9; i++) wm(i, $urandom());
    for (int i = 1; i < 9; i++) rchk(8'(4 * i), mdl[i], 1'b0);
    rchk(8'h40, 32'h0, 1'b1);
    rchk(OFS_INT_CLR, 32'h0, 1'b1);
    apb(1'b1, OFS_INT_STAT, 32'hffff_ffff);
    chk(err, 1'b1, "ro write");
    $display("test registers done");
    wm(0, {28'h0, TYPE_DATA});
    far.set_mode(1'b0, 1'b0);
    chk({toff, fwd, rev, dbit}, 34'h2_0000_0000, "data mode");
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    chk({spd, toff}, 17'h1, "dog ignored");
    far.start_pulse();
    chk(dbit, 1'b1, "data done");
    far.set_mode(1'b1, 1'b0);
    chk(toff, 1'b0, "mode left");
    $display("test data setting done");
    for (int m = 1; m < 3; m++) begin
      far.set_mode(m[0], m[1]);
      far.start_pulse();
      chk(spd, 16'h0, "start refused");
    end
    rchk(OFS_INT_STAT, 32'h5, 1'b0);
    wm(13 - 1, 32'h7);
    rchk(OFS_INT_STAT, 32'h0, 1'b0);
    $display("test refused start done");
    wm(0, 32'h2c);
    wm(3, 32'h0);
    wm(11, 32'h1);
    far.set_mode(1'b0, 1'b0);
    far.start_pulse();
    chk(dbit, 1'b0, "done cleared");
    chk({spd, dir}, {mdl[1][15:0], 1'b0}, "fast");
    chk({acc, dec}, {mdl[7][15:0], mdl[8][15:0]}, "ramps");
    chk({fwd, rev}, {mdl[4][15:0], mdl[5][15:0]}, "run limits");
    pins(1'b1, 1'b0);
    chk({spd, irq}, {mdl[2][15:0], 1'b0}, "creep masked");
    pins(1'b0, 1'b0);
    chk({spd, dbit}, {mdl[2][15:0], 1'b0}, "wait marker");
    pins(1'b0, 1'b1);
    chk({dbit, irq}, 2'b11, "dog done");
    stop_i <= 1'b1;
    tick(3);
    chk({fwd, rev}, {mdl[6][15:0], mdl[6][15:0]}, "stop limit");
    rchk(OFS_INT_STAT, 32'h3, 1'b0);
    wm(12, 32'h3);
    // The interrupt pin trails the status flop by one more edge
    tick(1);
    chk(irq, 1'b0, "irq cleared");
    $display("test dog done");
    stop_i <= 1'b0;
    pins(1'b1, 1'b0);
    wm(0, 32'h1c);
    wm(3, 32'h3);
    far.start_pulse();
    chk({spd, dir}, {mdl[1][15:0], 1'b1}, "reverse fast");
    pins(1'b0, 1'b0);
    chk(spd, mdl[2][15:0], "low polarity");
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
    for (int k = 0; k < 3; k++) begin
      chk(dbit, 1'b0, "shifting");
      enc_i <= 1'b1;
      tick(3);
      enc_i <= 1'b0;
      tick(3);
    end
    tick(2);
    chk(dbit, 1'b1, "shift done");
    $display("test shift done");
    end_of_test();
  end
endmodule : tb
